// *** src/synth_serial_program_loader.sv ***
// Three-wire serial program loader with divider decode, lock gating and post divider
`timescale 1ns/1ps
`default_nettype none

// Function
// (RQ1) Shift one data bit per rising serial clock
// (RQ2) Select low: ignore data and clock
// (RQ3) Select falling edge starts frequency acquisition
// (RQ4) Host re-toggles select to reacquire
// (RQ5) Host shifts 32 bits, drops select, waits
// (RQ6) Fixed field order with preamble and zeros
// (RQ7) Each field sent most significant bit first
// (RQ8) Denominator code sets wrapper M divisor
// (RQ9) Numerator code sets wrapper N divisor
// (RQ10) Host keeps M and N same set
// (RQ11) Host keeps N over M below 17/14
// (RQ12) Post divider code sets ratio 2..60
// (RQ13) Output duty free, rising edges exact
// (RQ14) Host keeps counts within 31, not both zero
// (RQ15) Integer select picks P, 1000 gives 25
// (RQ16) Lock only when both loops locked
// (RQ17) Last 32 bits received form the program
module synth_serial_program_loader
(
   input  wire logic       clk_i,                        // System clock, 100 MHz
   input  wire logic       nrst_i,                       // Synchronous reset, active low
   input  wire logic       serial_program_select_i,      // Select pin, high while loading
   input  wire logic       serial_program_clock_i,       // Serial clock pin
   input  wire logic       serial_program_data_in_i,     // Serial data pin
   input  wire logic       fractional_loop_locked_i,     // Fractional-N loop lock level
   input  wire logic       wrapper_loop_locked_i,        // Wrapper loop lock level
   input  wire logic       wrapper_osc_clk_i,            // Wrapper oscillator clock
   output logic            acquire_start_o,              // Pulse: start acquisition
   output logic            program_error_o,              // Fixed fields not zero
   output logic [4:0]      ones_count_o,                 // Times to divide by P
   output logic [4:0]      zeros_count_o,                // Times to divide by P-1
   output logic [5:0]      integer_divide_o,             // Integer divide value P
   output logic [5:0]      wrapper_m_divisor_o,          // Wrapper M divisor
   output logic [5:0]      wrapper_n_divisor_o,          // Wrapper N divisor
   output logic [5:0]      post_divide_ratio_o,          // Output post division ratio
   output logic            locked_o,                     // Lock indicator
   output logic            synth_clock_output_o          // Post divided clock
);

   // ------------------------------------------------------------------
   // Decode functions
   // ------------------------------------------------------------------

   // Wrapper divisor per code, shared by the M and N paths
   function automatic logic [5:0] wrap_divisor(input logic [2:0] code);
      logic [5:0] d;
      d = synth_loader_pkg::WRAP_DIV_C0;
      case (code)
         3'h0: d = synth_loader_pkg::WRAP_DIV_C0;
         3'h1: d = synth_loader_pkg::WRAP_DIV_C1;
         3'h2: d = synth_loader_pkg::WRAP_DIV_C2;
         3'h3: d = synth_loader_pkg::WRAP_DIV_C3;
         3'h4: d = synth_loader_pkg::WRAP_DIV_C4;
         3'h5: d = synth_loader_pkg::WRAP_DIV_C5;
         3'h6: d = synth_loader_pkg::WRAP_DIV_C6;
         default: d = synth_loader_pkg::WRAP_DIV_C7;
      endcase
      return d;
   endfunction

   // Post divide ratio; the code table is unknown, so twice the code,
   // held within the legal range
   function automatic logic [5:0] post_ratio(input logic [4:0] code);
      logic [5:0] r;
      r = {code, 1'b0};
      if (r < synth_loader_pkg::POSTDIV_MIN)
      begin
         r = synth_loader_pkg::POSTDIV_MIN;
      end
      else if (r > synth_loader_pkg::POSTDIV_MAX)
      begin
         r = synth_loader_pkg::POSTDIV_MAX;
      end
      return r;
   endfunction

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [1:0] sel_sync_reg;    // Select, two flops
   logic [1:0] sck_sync_reg;    // Serial clock, two flops
   logic [1:0] sdi_sync_reg;    // Serial data, two flops
   logic [1:0] flk_sync_reg;    // Fractional lock, two flops
   logic [1:0] wlk_sync_reg;    // Wrapper lock, two flops
   logic       sel_prev_reg;    // Select one cycle back, for edge
   logic       sck_prev_reg;    // Serial clock one cycle back, for edge

   // Only bit 1 of each synchroniser is read by logic
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         sel_sync_reg <= 2'h0;
         sck_sync_reg <= 2'h0;
         sdi_sync_reg <= 2'h0;
         flk_sync_reg <= 2'h0;
         wlk_sync_reg <= 2'h0;
         sel_prev_reg <= 1'b0;
         sck_prev_reg <= 1'b0;
      end
      else
      begin
         sel_sync_reg <= {sel_sync_reg[0], serial_program_select_i};
         sck_sync_reg <= {sck_sync_reg[0], serial_program_clock_i};
         sdi_sync_reg <= {sdi_sync_reg[0], serial_program_data_in_i};
         flk_sync_reg <= {flk_sync_reg[0], fractional_loop_locked_i};
         wlk_sync_reg <= {wlk_sync_reg[0], wrapper_loop_locked_i};
         sel_prev_reg <= sel_sync_reg[1];
         sck_prev_reg <= sck_sync_reg[1];
      end
   end

   // ------------------------------------------------------------------
   // Shift register and program latch
   // ------------------------------------------------------------------
   logic [31:0] shift_reg;       // Bits as they arrive
   logic [31:0] shift_next;
   logic [31:0] prog_reg;        // Program taken at select fall
   logic [31:0] prog_next;
   logic        start_reg;       // Acquisition start pulse
   logic        start_next;
   logic        sck_rise;        // Rising serial clock seen
   logic        sel_fall;        // Falling select seen

   assign sck_rise = sck_sync_reg[1] & ~sck_prev_reg;
   assign sel_fall = sel_prev_reg & ~sel_sync_reg[1];

   // Shift while selected; a 32-bit shift keeps only the latest 32 bits,
   // so short or long bursts leave the last 32 received as the program
   always_comb
   begin
      shift_next = shift_reg;
      prog_next  = prog_reg;
      start_next = 1'b0;
      if (sel_sync_reg[1] && sck_rise) // RQ1 RQ2
      begin
         shift_next = {shift_reg[30:0], sdi_sync_reg[1]}; // RQ7 RQ17
      end
      if (sel_fall)
      begin
         prog_next  = shift_reg; // RQ3
         start_next = 1'b1;      // RQ3
      end
   end

   // Register shift state
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         shift_reg <= synth_loader_pkg::PROG_RESET;
         prog_reg  <= synth_loader_pkg::PROG_RESET;
         start_reg <= 1'b0;
      end
      else
      begin
         shift_reg <= shift_next;
         prog_reg  <= prog_next;
         start_reg <= start_next;
      end
   end

   // ------------------------------------------------------------------
   // Field decode into registered outputs
   // ------------------------------------------------------------------
   logic [2:0] wrapper_denominator_select;  // Denominator code
   logic [2:0] wrapper_numerator_select;    // Numerator code
   logic [4:0] output_post_divider_select;  // Post divider code
   logic [3:0] int_sel;                     // Integer divider code
   logic       fixed_bad;                   // Preamble or fixed field wrong

   assign wrapper_denominator_select =
      prog_reg[synth_loader_pkg::DEN_MSB:synth_loader_pkg::DEN_LSB];
   assign wrapper_numerator_select =
      prog_reg[synth_loader_pkg::NUM_MSB:synth_loader_pkg::NUM_LSB];
   assign output_post_divider_select =
      prog_reg[synth_loader_pkg::POSTDIV_MSB:synth_loader_pkg::POSTDIV_LSB];
   assign int_sel = prog_reg[synth_loader_pkg::INTDIV_MSB:synth_loader_pkg::INTDIV_LSB];
   assign fixed_bad =
      (prog_reg[synth_loader_pkg::PREAMBLE_MSB:synth_loader_pkg::PREAMBLE_LSB]
         != synth_loader_pkg::PREAMBLE_VALUE) ||
      (prog_reg[synth_loader_pkg::FIXED_MSB:synth_loader_pkg::FIXED_LSB]
         != synth_loader_pkg::FIXED_VALUE); // RQ6

   logic [4:0] ones_reg;
   logic [4:0] zeros_reg;
   logic [5:0] pdiv_reg;
   logic [5:0] mdiv_reg;
   logic [5:0] ndiv_reg;
   logic [5:0] post_reg;
   logic       err_reg;
   logic       lock_reg;
   logic       lock_next;

   // Both loops must agree before lock is shown
   always_comb
   begin
      lock_next = flk_sync_reg[1] & wlk_sync_reg[1]; // RQ16
   end

   // Decoded values follow the latched program; they change only one edge after select fall latches it
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         ones_reg  <= 5'h00;
         zeros_reg <= 5'h00;
         pdiv_reg  <= synth_loader_pkg::INTDIV_OFFSET;
         mdiv_reg  <= synth_loader_pkg::WRAP_DIV_C0;
         ndiv_reg  <= synth_loader_pkg::WRAP_DIV_C0;
         post_reg  <= synth_loader_pkg::POSTDIV_MIN;
         err_reg   <= 1'b0;
         lock_reg  <= 1'b0;
      end
      else
      begin
         ones_reg  <= prog_reg[synth_loader_pkg::ONES_MSB:synth_loader_pkg::ONES_LSB]; // RQ6
         zeros_reg <= prog_reg[synth_loader_pkg::ZEROS_MSB:synth_loader_pkg::ZEROS_LSB]; // RQ6
         pdiv_reg  <= {2'h0, int_sel} + synth_loader_pkg::INTDIV_OFFSET; // RQ15
         mdiv_reg  <= wrap_divisor(wrapper_denominator_select); // RQ8
         ndiv_reg  <= wrap_divisor(wrapper_numerator_select);   // RQ9
         post_reg  <= post_ratio(output_post_divider_select);   // RQ12
         err_reg   <= fixed_bad;
         lock_reg  <= lock_next;
      end
   end

   // ------------------------------------------------------------------
   // Post divider on the oscillator clock
   // ------------------------------------------------------------------
   // Ratio crosses as a quasi-static word; it only moves at select fall,
   // well before lock, so a glitch during the change is tolerated.
   post_divider u_post_divider
   (
      .clk_i     (wrapper_osc_clk_i),
      .nrst_i    (nrst_i),
      .ratio_i   (post_reg),
      .clk_out_o (synth_clock_output_o)
   );

   assign acquire_start_o     = start_reg;
   assign program_error_o     = err_reg;
   assign ones_count_o        = ones_reg;
   assign zeros_count_o       = zeros_reg;
   assign integer_divide_o    = pdiv_reg;
   assign wrapper_m_divisor_o = mdiv_reg;
   assign wrapper_n_divisor_o = ndiv_reg;
   assign post_divide_ratio_o = post_reg;
   assign locked_o            = lock_reg;

endmodule

`default_nettype wire

// *** inc/synth_loader_pkg.sv ***
// Package with program layout, divisor codes and timing constants of the serial loader
package synth_loader_pkg;

   // ------------------------------------------------------------------
   // Program layout (bit positions in the 32-bit shift word, MSB first)
   // ------------------------------------------------------------------
   localparam int PROG_BITS        = 32;
   localparam int PREAMBLE_MSB     = 31;
   localparam int PREAMBLE_LSB     = 28;
   localparam int ONES_MSB         = 27;
   localparam int ONES_LSB         = 23;
   localparam int ZEROS_MSB        = 22;
   localparam int ZEROS_LSB        = 18;
   localparam int INTDIV_MSB       = 17;
   localparam int INTDIV_LSB       = 14;
   localparam int FIXED_MSB        = 13;
   localparam int FIXED_LSB        = 11;
   localparam int POSTDIV_MSB      = 10;
   localparam int POSTDIV_LSB      = 6;
   localparam int NUM_MSB          = 5;
   localparam int NUM_LSB          = 3;
   localparam int DEN_MSB          = 2;
   localparam int DEN_LSB          = 0;

   // ------------------------------------------------------------------
   // Fixed field values and reset values
   // ------------------------------------------------------------------
   localparam logic [3:0]  PREAMBLE_VALUE = 4'h0;
   localparam logic [2:0]  FIXED_VALUE    = 3'h0;
   localparam logic [31:0] PROG_RESET     = 32'h0000_0000;

   // ------------------------------------------------------------------
   // Integer divider: code 1000 gives 25, so P = code + 17
   // ------------------------------------------------------------------
   localparam logic [5:0]  INTDIV_OFFSET  = 6'h11;

   // ------------------------------------------------------------------
   // Wrapper M/N divisor values per 3-bit code
   // ------------------------------------------------------------------
   localparam logic [5:0]  WRAP_DIV_C0 = 6'h10; // 16
   localparam logic [5:0]  WRAP_DIV_C1 = 6'h10; // 16
   localparam logic [5:0]  WRAP_DIV_C2 = 6'h12; // 18
   localparam logic [5:0]  WRAP_DIV_C3 = 6'h11; // 17
   localparam logic [5:0]  WRAP_DIV_C4 = 6'h1F; // 31
   localparam logic [5:0]  WRAP_DIV_C5 = 6'h0E; // 14
   localparam logic [5:0]  WRAP_DIV_C6 = 6'h20; // 32
   localparam logic [5:0]  WRAP_DIV_C7 = 6'h0F; // 15

   // ------------------------------------------------------------------
   // Post divider range; code table is not available, ratio = code*2
   // clamped into the allowed range
   // ------------------------------------------------------------------
   localparam logic [5:0]  POSTDIV_MIN = 6'h02; // 2
   localparam logic [5:0]  POSTDIV_MAX = 6'h3C; // 60

   // ------------------------------------------------------------------
   // Lock declaration: consecutive clean cycles per loop; unused, lock follows the two synchronised levels
   // ------------------------------------------------------------------
   localparam int LOCK_CLEAN_CYCLES = 256;

endpackage

// *** src/post_divider.sv ***
// Post divider that turns the wrapper oscillator into the synthesizer clock output
`timescale 1ns/1ps
`default_nettype none

module post_divider
(
   input  wire logic       clk_i,     // Wrapper oscillator clock
   input  wire logic       nrst_i,    // Synchronous reset, active low
   input  wire logic [5:0] ratio_i,   // Division ratio, 2 to 60
   output logic            clk_out_o  // Divided clock, rising edges exact
);

   // ------------------------------------------------------------------
   // Counter state
   // ------------------------------------------------------------------
   logic [5:0] count_reg;     // Position within one output period
   logic [5:0] count_next;    // Next position
   logic       out_reg;       // Registered output level
   logic       out_next;      // Next output level

   // Count to ratio-1; output high for one input cycle only. Duty cycle is
   // traded away so that any ratio, odd or even, needs one comparator.
   always_comb
   begin
      count_next = count_reg + 6'h01;
      out_next   = 1'b0;
      if (count_reg >= ratio_i - 6'h01)
      begin
         count_next = 6'h00;
         out_next   = 1'b1; // RQ13
      end
   end

   // Register the counter
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         count_reg <= 6'h00;
         out_reg   <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         out_reg   <= out_next;
      end
   end

   assign clk_out_o = out_reg;

endmodule

`default_nettype wire

// *** verif/synth_serial_program_loader_asserts.sv ***
// Port-level assertion checker for the serial program loader
`timescale 1ns/1ps
`default_nettype none

module synth_loader_checker
(
   input  wire logic       clk_i,                    // System clock
   input  wire logic       nrst_i,                   // Reset, active low
   input  wire logic       serial_program_select_i,  // Select pin
   input  wire logic       fractional_loop_locked_i, // Loop lock
   input  wire logic       wrapper_loop_locked_i,    // Loop lock
   input  wire logic       wrapper_osc_clk_i,        // Divider clock
   input  wire logic       acquire_start_o,          // Start pulse
   input  wire logic       program_error_o,          // Bad fixed field
   input  wire logic [4:0] ones_count_o,             // Field
   input  wire logic [4:0] zeros_count_o,            // Field
   input  wire logic [5:0] integer_divide_o,         // P value
   input  wire logic [5:0] wrapper_m_divisor_o,      // M divisor
   input  wire logic [5:0] wrapper_n_divisor_o,      // N divisor
   input  wire logic [5:0] post_divide_ratio_o,      // Post ratio
   input  wire logic       locked_o,                 // Lock flag
   input  wire logic       synth_clock_output_o      // Divided clock
);
   // ---------------------------------------------
   // Properties on the system clock, except out_pulse_a on the oscillator clock
   // ---------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   logic [34:0] dec_w; // All decoded outputs together
   assign dec_w = {ones_count_o, zeros_count_o, integer_divide_o, wrapper_m_divisor_o,
                   wrapper_n_divisor_o, post_divide_ratio_o, program_error_o};

   // Select release as seen at the pin
   sequence sel_fall_s;
      $fell(serial_program_select_i);
   endsequence
   // Start pulse within the synchroniser latency
   sequence acq_s;
      ##[3:5] acquire_start_o;
   endsequence

   pulse_after_fall_a: assert property (sel_fall_s |-> acq_s)
      else $error("no start pulse after select fall");
   pulse_cause_a: assert property (acquire_start_o |-> !serial_program_select_i
      && ($past(serial_program_select_i, 4) || $past(serial_program_select_i, 5)))
      else $error("start pulse without select fall");
   pulse_single_a: assert property (acquire_start_o |=> !acquire_start_o)
      else $error("start pulse longer than one cycle");
   // Decoded outputs register the program one edge after the start pulse
   hold_outputs_a: assert property (!acquire_start_o |=> $stable(dec_w))
      else $error("decoded outputs moved without start");
   divisor_set_a: assert property (wrapper_m_divisor_o inside {[6'h0E:6'h12], 6'h1F, 6'h20}
      && wrapper_n_divisor_o inside {[6'h0E:6'h12], 6'h1F, 6'h20})
      else $error("wrapper divisor outside table");
   ratio_range_a: assert property (post_divide_ratio_o inside {[6'h02:6'h3C]}
      && integer_divide_o inside {[6'h11:6'h20]})
      else $error("ratio outside range");
   lock_gate_a: assert property ((!fractional_loop_locked_i || !wrapper_loop_locked_i)[*4]
      |-> !locked_o)
      else $error("lock shown with a loop unlocked");
   lock_follow_a: assert property ((fractional_loop_locked_i && wrapper_loop_locked_i)[*5]
      |-> locked_o)
      else $error("lock missing with both loops locked");
   // Ratio is at least two, so a high period never repeats
   out_pulse_a: assert property (@(posedge wrapper_osc_clk_i) disable iff (!nrst_i)
      synth_clock_output_o |=> !synth_clock_output_o)
      else $error("divided clock high too long");
endmodule

bind synth_serial_program_loader synth_loader_checker chk (
   .clk_i(clk_i), .nrst_i(nrst_i), .serial_program_select_i(serial_program_select_i),
   .fractional_loop_locked_i(fractional_loop_locked_i),
   .wrapper_loop_locked_i(wrapper_loop_locked_i), .wrapper_osc_clk_i(wrapper_osc_clk_i),
   .acquire_start_o(acquire_start_o), .program_error_o(program_error_o),
   .ones_count_o(ones_count_o), .zeros_count_o(zeros_count_o),
   .integer_divide_o(integer_divide_o), .wrapper_m_divisor_o(wrapper_m_divisor_o),
   .wrapper_n_divisor_o(wrapper_n_divisor_o), .post_divide_ratio_o(post_divide_ratio_o),
   .locked_o(locked_o), .synth_clock_output_o(synth_clock_output_o));

`default_nettype wire

// *** verif/serial_host_model.sv ***
// Behavioural host that shifts programs over the three-wire link
`timescale 1ns/1ps
`default_nettype none

module serial_host_model
(
   input  wire logic clk_i, // Bench clock
   output var logic  sel_o, // Select pin
   output var logic  sck_o, // Serial clock, still between frames
   output var logic  sdi_o  // Serial data
);
   // ---------------------------------------------
   // Link tasks, pins change on falling edges only
   // ---------------------------------------------
   initial
   begin
      sel_o = 1'b0;
      sck_o = 1'b0;
      sdi_o = 1'b0;
   end

   // Shift n bits of w, MSB first; cs low sends a frame the device must ignore
   task automatic load(input logic [39:0] w, input int n, input logic cs);
      @(negedge clk_i);
      sel_o = cs;
      for (int i = n - 1; i >= 0; i--)
      begin
         sdi_o = w[i];
         repeat (2) @(negedge clk_i);
         sck_o = 1'b1;
         repeat (4) @(negedge clk_i);
         sck_o = 1'b0;
         repeat (4) @(negedge clk_i);
      end
      sel_o = 1'b0;
      // Released data line shows no stale bit
      sdi_o = ~sdi_o;
   endtask

   // Reacquire with the program already held
   task automatic retoggle();
      @(negedge clk_i);
      sel_o = 1'b1;
      repeat (5) @(negedge clk_i);
      sel_o = 1'b0;
   endtask
endmodule

`default_nettype wire

// *** verif/synth_serial_program_loader_test.sv ***
// Self-checking testbench of the serial program loader
`timescale 1ns/1ps
`default_nettype none

module synth_serial_program_loader_test;
   // ---------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------
   logic        clk_i, nrst_i, osc, frac, wrap; // Clocks, reset, lock levels
   logic        sel, sck, sdi;                  // Link pins from the host
   logic        acq, perr, lck, sout;           // Single-bit outputs
   logic [4:0]  ones, zeros;                    // Count fields
   logic [5:0]  pdiv, mdiv, ndiv, post;         // Divider values
   logic [31:0] last_prog;                      // Program held by the device
   int          err_total, n_checks;            // Report counters

   synth_serial_program_loader dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .serial_program_select_i(sel),
      .serial_program_clock_i(sck), .serial_program_data_in_i(sdi),
      .fractional_loop_locked_i(frac), .wrapper_loop_locked_i(wrap),
      .wrapper_osc_clk_i(osc), .acquire_start_o(acq), .program_error_o(perr),
      .ones_count_o(ones), .zeros_count_o(zeros), .integer_divide_o(pdiv),
      .wrapper_m_divisor_o(mdiv), .wrapper_n_divisor_o(ndiv),
      .post_divide_ratio_o(post), .locked_o(lck), .synth_clock_output_o(sout));
   serial_host_model host (.clk_i(clk_i), .sel_o(sel), .sck_o(sck), .sdi_o(sdi));

   // Unrelated divider clock keeps the post divider busy
   initial
   begin
      clk_i = 1'b0;
      osc = 1'b0;
      fork
         forever #5 clk_i = ~clk_i;
         forever #4 osc = ~osc;
      join
   end

   // ---------------------------------------------
   // Shared checks and expectations
   // ---------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Bounded wait for the start pulse, then for the decoded outputs
   task automatic wait_acq();
      int k;
      k = 0;
      while (acq !== 1'b1 && k < 40)
      begin
         @(posedge clk_i);
         #1;
         k++;
      end
      if (acq !== 1'b1)
      begin
         err_total++;
         print_verdict();
      end
      // Outputs take the latched program one edge after the pulse
      repeat (2) @(negedge clk_i);
   endtask

   function automatic logic [5:0] wdiv(input logic [2:0] c);
      case (c)
         3'h2: return 6'h12;
         3'h3: return 6'h11;
         3'h4: return 6'h1F;
         3'h5: return 6'h0E;
         3'h6: return 6'h20;
         3'h7: return 6'h0F;
         default: return 6'h10;
      endcase
   endfunction

   // Ratio is twice the code, held inside 2..60
   function automatic logic [5:0] pexp(input logic [4:0] c);
      logic [5:0] r;
      r = {c, 1'b0};
      if (r < 6'h02)
         r = 6'h02;
      if (r > 6'h3C)
         r = 6'h3C;
      return r;
   endfunction

   // Same code for N and M keeps one set and a ratio of one
   function automatic logic [31:0] mk(input logic [3:0] pre, input logic [2:0] c,
                                      input logic [4:0] pc, input logic [2:0] fx);
      return {pre, 5'(c + 3), 5'(7 - c), 4'(8 + c), fx, pc, c, c};
   endfunction

   task automatic check_all(input logic [31:0] p);
      chk(ones, p[27:23]);
      chk(zeros, p[22:18]);
      chk(pdiv, 6'(p[17:14]) + 6'h11);
      chk(post, pexp(p[10:6]));
      chk(ndiv, wdiv(p[5:3]));
      chk(mdiv, wdiv(p[2:0]));
      chk(perr, (p[31:28] != 4'h0) || (p[13:11] != 3'h0));
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_codes();
      for (int c = 0; c < 8; c++)
      begin
         last_prog = mk(4'h0, 3'(c), 5'(c * 4 + c / 7 * 3), 3'h0);
         host.load(40'(last_prog), 32, 1'b1);
         wait_acq();
         check_all(last_prog);
      end
      $display("codes test done");
   endtask

   // Frame with select low, then a bare reacquire
   task automatic t_ignore();
      host.load(40'(mk(4'h0, 3'h2, 5'h05, 3'h0)), 32, 1'b0);
      chk(acq, 1'b0);
      host.retoggle();
      wait_acq();
      check_all(last_prog);
      $display("ignore test done");
   endtask

   task automatic t_long();
      last_prog = mk(4'h0, 3'h6, 5'h11, 3'h0);
      host.load({8'hA5, last_prog}, 40, 1'b1);
      wait_acq();
      check_all(last_prog);
      $display("long frame test done");
   endtask

   // Nonzero preamble, then nonzero fixed field
   task automatic t_err();
      for (int i = 0; i < 2; i++)
      begin
         last_prog = mk(i == 0 ? 4'h9 : 4'h0, 3'h1, 5'h03, i == 0 ? 3'h0 : 3'h5);
         host.load(40'(last_prog), 32, 1'b1);
         wait_acq();
         check_all(last_prog);
      end
      $display("error field test done");
   endtask

   task automatic t_lock();
      frac = 1'b1;
      repeat (6) @(negedge clk_i);
      chk(lck, 1'b0);
      wrap = 1'b1;
      repeat (6) @(negedge clk_i);
      chk(lck, 1'b1);
      frac = 1'b0;
      repeat (6) @(negedge clk_i);
      chk(lck, 1'b0);
      $display("lock test done");
   endtask

   // Divided clock period, in oscillator cycles, against the programmed ratio
   task automatic t_outclk();
      int n;
      int k;
      n = 0;
      k = 0;
      while (sout !== 1'b1 && k < 64)
      begin
         @(posedge osc);
         #1;
         k++;
      end
      do
      begin
         @(posedge osc);
         #1;
         n++;
      end
      while (sout !== 1'b1 && n < 64);
      chk(32'(n), 32'(pexp(last_prog[10:6])));
      $display("output clock test done");
   endtask

   // Hang guard
   initial
   begin
      #600000;
      err_total++;
      print_verdict();
   end

   initial
   begin
      err_total = 0;
      n_checks = 0;
      nrst_i = 1'b0;
      frac = 1'b0;
      wrap = 1'b0;
      last_prog = 32'h0000_0000;
      repeat (10) @(negedge clk_i);
      nrst_i = 1'b1;
      check_all(32'h0000_0000);
      chk(lck, 1'b0);
      t_codes();
      t_ignore();
      t_long();
      t_err();
      t_lock();
      t_outclk();
      print_verdict();
   end
endmodule

`default_nettype wire
